// [common/fsr_cfg.svh]
// Purpose: constants of the fault status and sensor readout block
// Assumes: 200 MHz core clock, byte-wide register file behind the I2C port
// Notes:   included by bare name; definitions only
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH
`define FSR_ADR_PWR_CTRL   8'h04
`define FSR_ADR_FAULT_CTRL 8'h0b
`define FSR_ADR_OTW_GAIN   8'h16
`define FSR_ADR_RECOVERY   8'h17
`define FSR_ADR_STAT_A     8'h18
`define FSR_ADR_STAT_B     8'h19
`define FSR_ADR_BAT        8'h1a
`define FSR_ADR_TEMP       8'h1b
`define FSR_RST_PWR_CTRL   8'h01
`define FSR_RST_FAULT_CTRL 8'h00
`define FSR_RST_OTW_GAIN   8'h00
`define FSR_RST_RECOVERY   8'h00
`define FSR_THERM_OFF_BIT  0
`define FSR_UV_POWER_STAGE_SUPPLY_BIT    7
`define FSR_UV_VREG_BIT    6
`define FSR_OTF_BIT        1
`define FSR_OTW_BIT        0
`define FSR_LIM_R_BIT      7
`define FSR_CLIP_R_BIT     6
`define FSR_OC_R_BIT       5
`define FSR_BAT_R_BIT      4
`define FSR_LIM_L_BIT      3
`define FSR_CLIP_L_BIT     2
`define FSR_OC_L_BIT       1
`define FSR_BAT_L_BIT      0
`define FSR_GAIN_L_LSB     0
`define FSR_GAIN_R_LSB     4
`define FSR_MANUAL_RECOVERY_TRIGGER_BIT       7
`define FSR_AUTORECOVERY_ATTEMPT_LIMIT_LSB     4
`define FSR_UNDERVOLTAGE_AUTO_RECOVERY_BIT    2
`define FSR_OVERTEMPERATURE_AUTO_RECOVERY_BIT    1
`define FSR_OVERCURRENT_AUTO_RECOVERY_BIT    0
`define FSR_TEMP_OFS_C     60
`define FSR_OTF_C          145
`define FSR_OTW_C          117
`define FSR_OTF_CODE       8'((`FSR_OTF_C) + (`FSR_TEMP_OFS_C))
`define FSR_OTW_CODE       8'((`FSR_OTW_C) + (`FSR_TEMP_OFS_C))
`define FSR_CLK_NS         5
`define FSR_RETRY_NS       1000
`define FSR_RETRY_CYC      8'(((`FSR_RETRY_NS) + (`FSR_CLK_NS) - 1) / (`FSR_CLK_NS))
`define FSR_I2C_ADDR       7'h10
`define FSR_BYTE_BITS      4'h8
`endif

// [common/fsr_pkg.sv]
// Purpose: types of the fault status and sensor readout block
// Assumes: nothing beyond the cfg header
// Notes:   state codes written out
package fsr_pkg;
	typedef enum logic [3:0] {
		FSR_I_IDLE = 4'h0,
		FSR_I_ADDR = 4'h1,
		FSR_I_AACK = 4'h2,
		FSR_I_SUB  = 4'h3,
		FSR_I_SACK = 4'h4,
		FSR_I_WR   = 4'h5,
		FSR_I_WACK = 4'h6,
		FSR_I_RD   = 4'h7,
		FSR_I_RACK = 4'h8
	} fsr_i2c_state_t;
	typedef enum logic [1:0] {
		FSR_R_RUN  = 2'h0,
		FSR_R_OFF  = 2'h1,
		FSR_R_WAIT = 2'h2
	} fsr_rcv_state_t;
endpackage : fsr_pkg

// [src/fsr_sync.sv]
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: each bit is an independent level
// Notes:   only the second stage leaves the module
`timescale 1ns/100ps
module fsr_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r <= '0;
			dout   <= '0;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule : fsr_sync

// [src/fsr_top.sv]
// Purpose: fault status, sensor readout and fault recovery with I2C register access
// Assumes: converter codes arrive on clk; comparator pins and I2C pins are asynchronous
// Notes:   SDA is open drain, pulled low while sdaOe is high
`timescale 1ns/100ps
`include "fsr_cfg.svh"
module fsr_top
	import fsr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	input  wire logic       powerStageSupplyLow,
	input  wire logic       regulatorLow,
	input  wire logic       leftOvercurrent,
	input  wire logic       rightOvercurrent,
	input  wire logic       leftLimiterActive,
	input  wire logic       rightLimiterActive,
	input  wire logic       leftClip,
	input  wire logic       rightClip,
	input  wire logic       leftBatteryAboveThreshold,
	input  wire logic       rightBatteryAboveThreshold,
	input  wire logic [7:0] tempCode,
	input  wire logic       tempValid,
	input  wire logic [7:0] batCode,
	input  wire logic       batValid,
	output logic            tempAdcEn,
	output logic      [1:0] leftThermalGainCut,
	output logic      [1:0] rightThermalGainCut,
	output logic      [7:0] faultReactionCfg,
	output logic            ampShutdown
);
	logic [11:0]    pinSync;
	logic           sclS;
	logic           sdaS;
	logic           sclD_r;
	logic           sdaD_r;
	logic           sclRise;
	logic           sclFall;
	logic           startDet;
	logic           stopDet;
	fsr_i2c_state_t iState_r;
	fsr_i2c_state_t iState_nxt;
	logic [7:0]     shift_r;
	logic [7:0]     shift_nxt;
	logic [3:0]     bitCnt_r;
	logic [3:0]     bitCnt_nxt;
	logic [7:0]     ptr_r;
	logic [7:0]     ptr_nxt;
	logic           rnw_r;
	logic           rnw_nxt;
	logic           mAck_r;
	logic           mAck_nxt;
	logic           sdaOe_nxt;
	logic           wrStb;
	logic [7:0]     rdData;
	logic [7:0]     pwrCtrl_r;
	logic [7:0]     pwrCtrl_nxt;
	logic [7:0]     otwGain_r;
	logic [7:0]     otwGain_nxt;
	logic [7:0]     recovery_r;
	logic [7:0]     recovery_nxt;
	logic [7:0]     faultReactionCfg_nxt;
	logic           mrcvPulse_r;
	logic           mrcvPulse_nxt;
	logic [7:0]     tempReg_r;
	logic [7:0]     tempReg_nxt;
	logic [7:0]     batReg_r;
	logic [7:0]     batReg_nxt;
	logic [7:0]     statA_r;
	logic [7:0]     statA_nxt;
	logic [7:0]     statB_r;
	logic [7:0]     statB_nxt;
	logic           sensorOn;
	logic           tempAdcEn_nxt;
	logic [1:0]     leftGain_nxt;
	logic [1:0]     rightGain_nxt;
	fsr_rcv_state_t rState_r;
	fsr_rcv_state_t rState_nxt;
	logic [7:0]     waitCnt_r;
	logic [7:0]     waitCnt_nxt;
	logic [2:0]     attempts_r;
	logic [2:0]     attempts_nxt;
	logic [2:0]     attemptLimit;
	logic           faultUv;
	logic           faultOt;
	logic           faultOc;
	logic           anyFault;
	logic           needManual;
	logic           ampShutdown_nxt;

	// pin synchronisers
	fsr_sync #(.W(12)) uSync (
		.clk    (clk),
		.sys_rst(sys_rst),
		.din    ({sclIn, sdaIn, powerStageSupplyLow, regulatorLow, leftOvercurrent,
		          rightOvercurrent, leftLimiterActive, rightLimiterActive, leftClip,
		          rightClip, leftBatteryAboveThreshold, rightBatteryAboveThreshold}),
		.dout   (pinSync)
	);
	assign sclS     = pinSync[11];
	assign sdaS     = pinSync[10];
	assign sclRise  = sclS & ~sclD_r;
	assign sclFall  = ~sclS & sclD_r;
	assign startDet = sclS & sclD_r & ~sdaS & sdaD_r;
	assign stopDet  = sclS & sclD_r & sdaS & ~sdaD_r;

	// register read mux
	always_comb begin
		case (ptr_r)
			`FSR_ADR_PWR_CTRL:   rdData = pwrCtrl_r;
			`FSR_ADR_FAULT_CTRL: rdData = faultReactionCfg;
			`FSR_ADR_OTW_GAIN:   rdData = otwGain_r;
			`FSR_ADR_RECOVERY:   rdData = recovery_r;
			`FSR_ADR_STAT_A:     rdData = statA_r;
			`FSR_ADR_STAT_B:     rdData = statB_r;
			`FSR_ADR_BAT:        rdData = batReg_r;
			`FSR_ADR_TEMP:       rdData = tempReg_r;
			default:             rdData = 8'h00;
		endcase
	end

	// i2c slave: address, subaddress, burst write and burst read
	always_comb begin
		iState_nxt = iState_r;
		shift_nxt  = shift_r;
		bitCnt_nxt = bitCnt_r;
		ptr_nxt    = ptr_r;
		rnw_nxt    = rnw_r;
		mAck_nxt   = mAck_r;
		sdaOe_nxt  = sdaOe;
		wrStb      = 1'b0;
		if (startDet) begin
			iState_nxt = FSR_I_ADDR;
			bitCnt_nxt = 4'h0;
			sdaOe_nxt  = 1'b0;
		end else if (stopDet) begin
			iState_nxt = FSR_I_IDLE;
			sdaOe_nxt  = 1'b0;
		end else begin
			case (iState_r)
				FSR_I_ADDR, FSR_I_SUB, FSR_I_WR: begin
					if (sclRise) begin
						shift_nxt  = {shift_r[6:0], sdaS};
						bitCnt_nxt = bitCnt_r + 4'h1;
					end else if (sclFall && bitCnt_r == `FSR_BYTE_BITS) begin
						sdaOe_nxt = 1'b1;
						if (iState_r == FSR_I_ADDR) begin
							if (shift_r[7:1] == `FSR_I2C_ADDR) begin
								rnw_nxt    = shift_r[0];
								iState_nxt = FSR_I_AACK;
							end else begin
								sdaOe_nxt  = 1'b0;
								iState_nxt = FSR_I_IDLE;
							end
						end else if (iState_r == FSR_I_SUB) begin
							ptr_nxt    = shift_r;
							iState_nxt = FSR_I_SACK;
						end else begin
							wrStb      = 1'b1;
							iState_nxt = FSR_I_WACK;
						end
					end
				end
				FSR_I_AACK, FSR_I_SACK, FSR_I_WACK: begin
					if (sclFall) begin
						bitCnt_nxt = 4'h0;
						sdaOe_nxt  = 1'b0;
						iState_nxt = FSR_I_WR;
						if (iState_r == FSR_I_AACK && !rnw_r) begin
							iState_nxt = FSR_I_SUB;
						end else if (iState_r == FSR_I_AACK) begin
							shift_nxt  = rdData;
							sdaOe_nxt  = ~rdData[7];
							bitCnt_nxt = 4'h1;
							iState_nxt = FSR_I_RD;
						end else if (iState_r == FSR_I_WACK) begin
							ptr_nxt = ptr_r + 8'h01;
						end
					end
				end
				FSR_I_RD: begin
					if (sclFall && bitCnt_r == `FSR_BYTE_BITS) begin
						sdaOe_nxt  = 1'b0;
						ptr_nxt    = ptr_r + 8'h01;
						iState_nxt = FSR_I_RACK;
					end else if (sclFall) begin
						shift_nxt  = {shift_r[6:0], 1'b0};
						sdaOe_nxt  = ~shift_r[6];
						bitCnt_nxt = bitCnt_r + 4'h1;
					end
				end
				FSR_I_RACK: begin
					if (sclRise) begin
						mAck_nxt = ~sdaS;
					end else if (sclFall && mAck_r) begin
						shift_nxt  = rdData;
						sdaOe_nxt  = ~rdData[7];
						bitCnt_nxt = 4'h1;
						iState_nxt = FSR_I_RD;
					end else if (sclFall) begin
						iState_nxt = FSR_I_IDLE;
					end
				end
				default: begin
					sdaOe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclD_r   <= 1'b1;
			sdaD_r   <= 1'b1;
			iState_r <= FSR_I_IDLE;
			shift_r  <= 8'h00;
			bitCnt_r <= 4'h0;
			ptr_r    <= 8'h00;
			rnw_r    <= 1'b0;
			mAck_r   <= 1'b0;
			sdaOe    <= 1'b0;
			sdaOut   <= 1'b0;
		end else begin
			sclD_r   <= sclS;
			sdaD_r   <= sdaS;
			iState_r <= iState_nxt;
			shift_r  <= shift_nxt;
			bitCnt_r <= bitCnt_nxt;
			ptr_r    <= ptr_nxt;
			rnw_r    <= rnw_nxt;
			mAck_r   <= mAck_nxt;
			sdaOe    <= sdaOe_nxt;
			sdaOut   <= 1'b0;
		end
	end

	// writable registers; read-only addresses ignore writes
	always_comb begin
		pwrCtrl_nxt          = pwrCtrl_r;
		faultReactionCfg_nxt = faultReactionCfg;
		otwGain_nxt          = otwGain_r;
		recovery_nxt         = recovery_r;
		mrcvPulse_nxt        = 1'b0;
		if (wrStb) begin
			case (ptr_r)
				`FSR_ADR_PWR_CTRL:   pwrCtrl_nxt = shift_r;
				`FSR_ADR_FAULT_CTRL: faultReactionCfg_nxt = shift_r;
				`FSR_ADR_OTW_GAIN:   otwGain_nxt = shift_r;
				`FSR_ADR_RECOVERY: begin
					recovery_nxt                = shift_r;
					recovery_nxt[`FSR_MANUAL_RECOVERY_TRIGGER_BIT] = 1'b0;
					mrcvPulse_nxt               = shift_r[`FSR_MANUAL_RECOVERY_TRIGGER_BIT];
				end
				default: pwrCtrl_nxt = pwrCtrl_r;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwrCtrl_r        <= `FSR_RST_PWR_CTRL;
			faultReactionCfg <= `FSR_RST_FAULT_CTRL;
			otwGain_r        <= `FSR_RST_OTW_GAIN;
			recovery_r       <= `FSR_RST_RECOVERY;
			mrcvPulse_r      <= 1'b0;
		end else begin
			pwrCtrl_r        <= pwrCtrl_nxt;
			faultReactionCfg <= faultReactionCfg_nxt;
			otwGain_r        <= otwGain_nxt;
			recovery_r       <= recovery_nxt;
			mrcvPulse_r      <= mrcvPulse_nxt;
		end
	end

	// readings, live status flags and thermal gain cut
	assign sensorOn = ~pwrCtrl_r[`FSR_THERM_OFF_BIT];
	always_comb begin
		tempAdcEn_nxt = sensorOn;
		tempReg_nxt   = (tempValid && sensorOn) ? tempCode : tempReg_r;
		batReg_nxt    = batValid ? batCode : batReg_r;
		statA_nxt     = 8'h00;
		statA_nxt[`FSR_UV_POWER_STAGE_SUPPLY_BIT] = pinSync[9];
		statA_nxt[`FSR_UV_VREG_BIT] = pinSync[8];
		statA_nxt[`FSR_OTF_BIT] = sensorOn && (tempReg_r > `FSR_OTF_CODE);
		statA_nxt[`FSR_OTW_BIT] = sensorOn && (tempReg_r > `FSR_OTW_CODE);
		statB_nxt[`FSR_OC_L_BIT]   = pinSync[7];
		statB_nxt[`FSR_OC_R_BIT]   = pinSync[6];
		statB_nxt[`FSR_LIM_L_BIT]  = pinSync[5];
		statB_nxt[`FSR_LIM_R_BIT]  = pinSync[4];
		statB_nxt[`FSR_CLIP_L_BIT] = pinSync[3];
		statB_nxt[`FSR_CLIP_R_BIT] = pinSync[2];
		statB_nxt[`FSR_BAT_L_BIT]  = pinSync[1];
		statB_nxt[`FSR_BAT_R_BIT]  = pinSync[0];
		leftGain_nxt  = 2'h0;
		rightGain_nxt = 2'h0;
		if (statA_r[`FSR_OTW_BIT]) begin
			leftGain_nxt  = otwGain_r[`FSR_GAIN_L_LSB +: 2];
			rightGain_nxt = otwGain_r[`FSR_GAIN_R_LSB +: 2];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tempAdcEn           <= 1'b0;
			tempReg_r           <= 8'h00;
			batReg_r            <= 8'h00;
			statA_r             <= 8'h00;
			statB_r             <= 8'h00;
			leftThermalGainCut  <= 2'h0;
			rightThermalGainCut <= 2'h0;
		end else begin
			tempAdcEn           <= tempAdcEn_nxt;
			tempReg_r           <= tempReg_nxt;
			batReg_r            <= batReg_nxt;
			statA_r             <= statA_nxt;
			statB_r             <= statB_nxt;
			leftThermalGainCut  <= leftGain_nxt;
			rightThermalGainCut <= rightGain_nxt;
		end
	end

	// fault recovery sequencer
	assign faultUv  = statA_r[`FSR_UV_POWER_STAGE_SUPPLY_BIT] | statA_r[`FSR_UV_VREG_BIT];
	assign faultOt  = statA_r[`FSR_OTF_BIT];
	assign faultOc  = statB_r[`FSR_OC_L_BIT] | statB_r[`FSR_OC_R_BIT];
	assign anyFault = faultUv | faultOt | faultOc;
	assign needManual = (faultUv & ~recovery_r[`FSR_UNDERVOLTAGE_AUTO_RECOVERY_BIT])
	                  | (faultOt & ~recovery_r[`FSR_OVERTEMPERATURE_AUTO_RECOVERY_BIT])
	                  | (faultOc & ~recovery_r[`FSR_OVERCURRENT_AUTO_RECOVERY_BIT]);
	assign attemptLimit = {1'b0, recovery_r[`FSR_AUTORECOVERY_ATTEMPT_LIMIT_LSB +: 2]} + 3'h1;
	always_comb begin
		rState_nxt   = rState_r;
		waitCnt_nxt  = waitCnt_r;
		attempts_nxt = attempts_r;
		case (rState_r)
			FSR_R_RUN: begin
				if (anyFault && (needManual || attempts_r >= attemptLimit)) begin
					rState_nxt = FSR_R_OFF;
				end else if (anyFault) begin
					rState_nxt  = FSR_R_WAIT;
					waitCnt_nxt = 8'h00;
				end
			end
			FSR_R_WAIT: begin
				waitCnt_nxt = waitCnt_r + 8'h01;
				if (waitCnt_r == `FSR_RETRY_CYC - 8'h01) begin
					attempts_nxt = attempts_r + 3'h1;
					rState_nxt   = FSR_R_RUN;
				end
			end
			FSR_R_OFF: begin
				if (mrcvPulse_r) begin
					attempts_nxt = 3'h0;
					rState_nxt   = FSR_R_RUN;
				end
			end
			default: rState_nxt = FSR_R_RUN;
		endcase
		ampShutdown_nxt = (rState_nxt != FSR_R_RUN);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rState_r    <= FSR_R_RUN;
			waitCnt_r   <= 8'h00;
			attempts_r  <= 3'h0;
			ampShutdown <= 1'b0;
		end else begin
			rState_r    <= rState_nxt;
			waitCnt_r   <= waitCnt_nxt;
			attempts_r  <= attempts_nxt;
			ampShutdown <= ampShutdown_nxt;
		end
	end

	// checks
	chk_otf_needs_otw: assert property (@(posedge clk) disable iff (sys_rst)
		statA_r[`FSR_OTF_BIT] |-> statA_r[`FSR_OTW_BIT])
		else $error("overtemperature fault without warning");
	chk_otw_code_gate: assert property (@(posedge clk) disable iff (sys_rst)
		(sensorOn && tempReg_r > `FSR_OTW_CODE) |=> statA_r[`FSR_OTW_BIT])
		else $error("warning flag missed above threshold");
	chk_gain_cut_apply: assert property (@(posedge clk) disable iff (sys_rst)
		statA_r[`FSR_OTW_BIT] && $stable(otwGain_r)
		|=> leftThermalGainCut == otwGain_r[`FSR_GAIN_L_LSB +: 2]
		 && rightThermalGainCut == otwGain_r[`FSR_GAIN_R_LSB +: 2])
		else $error("gain cut not applied during warning");
	chk_gain_cut_clear: assert property (@(posedge clk) disable iff (sys_rst)
		!statA_r[`FSR_OTW_BIT] |=> leftThermalGainCut == 2'h0 && rightThermalGainCut == 2'h0)
		else $error("gain cut held after warning ended");
	chk_sensor_enable: assert property (@(posedge clk) disable iff (sys_rst)
		pwrCtrl_r[`FSR_THERM_OFF_BIT] |=> !tempAdcEn && !statA_r[`FSR_OTF_BIT])
		else $error("sensor active while powered down");
	chk_uv_flag: assert property (@(posedge clk) disable iff (sys_rst)
		pinSync[9] |=> statA_r[`FSR_UV_POWER_STAGE_SUPPLY_BIT])
		else $error("supply undervoltage not flagged");
	chk_manual_off: assert property (@(posedge clk) disable iff (sys_rst)
		rState_r == FSR_R_RUN && anyFault && needManual |=> ampShutdown [*2])
		else $error("manual fault did not keep amplifier off");
	chk_retry_delay: assert property (@(posedge clk) disable iff (sys_rst)
		rState_r == FSR_R_RUN && anyFault && !needManual && attempts_r < attemptLimit
		|=> ampShutdown ##[1:250] !ampShutdown)
		else $error("automatic retry not released in time");
	chk_attempt_cap: assert property (@(posedge clk) disable iff (sys_rst)
		attempts_r <= attemptLimit || rState_r == FSR_R_OFF || !$stable(recovery_r))
		else $error("recovery attempts exceed limit");
	chk_manual_recovery_trigger_release: assert property (@(posedge clk) disable iff (sys_rst)
		rState_r == FSR_R_OFF && mrcvPulse_r |=> !ampShutdown && attempts_r == 3'h0)
		else $error("manual recovery trigger ignored");
	cov_auto_retry: cover property (@(posedge clk) disable iff (sys_rst)
		rState_r == FSR_R_WAIT ##1 rState_r == FSR_R_RUN);
	cov_manual_recover: cover property (@(posedge clk) disable iff (sys_rst)
		rState_r == FSR_R_OFF && mrcvPulse_r);
	cov_reg_read: cover property (@(posedge clk) disable iff (sys_rst)
		iState_r == FSR_I_RD && ptr_r == `FSR_ADR_TEMP);
	cov_gain_cut: cover property (@(posedge clk) disable iff (sys_rst)
		leftThermalGainCut != 2'h0);
endmodule : fsr_top

// [test/fsr_host_model.sv]
// Purpose: I2C host model driving the register port
// Assumes: SCL phases of 10 clk, pull-up on SDA
// Notes:   tasks are called from the bench
`timescale 1ns/100ps
`include "fsr_cfg.svh"
module fsr_host_model (
	input  wire logic clk,
	input  wire logic sdaWire,
	output logic      scl,
	output logic      sdaDrv
);
	logic ackSeen;
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic edge4(input logic a, input logic b, input logic c);
		tick(5);
		sdaDrv = a;
		tick(5);
		scl = 1'b1;
		tick(5);
		sdaDrv = b;
		tick(5);
		scl = c;
	endtask : edge4
	task automatic bitIn(output logic b);
		tick(5);
		sdaDrv = 1'b1;
		tick(5);
		scl = 1'b1;
		tick(5);
		b = sdaWire;
		tick(5);
		scl = 1'b0;
	endtask : bitIn
	task automatic byteOut(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			edge4(d[i], d[i], 1'b0);
		end
		bitIn(ackSeen);
	endtask : byteOut
	task automatic wr(input logic [7:0] sub, input logic [7:0] d);
		edge4(1'b1, 1'b0, 1'b0);
		byteOut({`FSR_I2C_ADDR, 1'b0});
		byteOut(sub);
		byteOut(d);
		edge4(1'b0, 1'b1, 1'b1);
	endtask : wr
	// status flags are learned only by reading them back
	task automatic rd(input logic [7:0] sub, output logic [7:0] d);
		edge4(1'b1, 1'b0, 1'b0);
		byteOut({`FSR_I2C_ADDR, 1'b0});
		byteOut(sub);
		edge4(1'b1, 1'b0, 1'b0);
		byteOut({`FSR_I2C_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) begin
			bitIn(d[i]);
		end
		edge4(1'b1, 1'b1, 1'b0);
		edge4(1'b0, 1'b1, 1'b1);
	endtask : rd
endmodule : fsr_host_model

// [test/testbench.sv]
// Purpose: self-checking bench of the fault status block
// Assumes: host model on the I2C pins, other inputs driven at falling edge
// Notes:   expectations come from an integer model of the registers
`timescale 1ns/100ps
module testbench;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic [9:0] pins = '0;
	logic [7:0] tempCode = '0;
	logic [7:0] batCode = '0;
	logic       tempValid = 1'b0;
	logic       batValid = 1'b0;
	logic       sdaOut, sdaOe, tempAdcEn, ampShutdown, scl, sdaDrv;
	logic [1:0] leftCut, rightCut;
	logic [7:0] faultCfg, rd, v, g;
	int         miscompares = 0;
	int         checksDone = 0;
	int         seed = 32'h01ebfef4;
	int         lim, rel, t;
	logic [7:0] rstAdr [$] = {8'h0b, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b};
	logic [7:0] codes [$] = {8'h54, 8'hb1, 8'hb2, 8'hcd, 8'hce, 8'hff, 8'h00};
	int         pinIx [$] = {2, 0, 1, 3, 2};
	logic [7:0] modeBit [$] = {8'h01, 8'h04, 8'h04, 8'h01, 8'h06};
	wire        sdaWire = sdaDrv & ~sdaOe;
	always #2.5 clk = ~clk;
	fsr_host_model u_host (.clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv));
	fsr_top u_dut (
		.clk(clk), .sys_rst(sys_rst), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .powerStageSupplyLow(pins[0]), .regulatorLow(pins[1]),
		.leftOvercurrent(pins[2]), .rightOvercurrent(pins[3]),
		.leftLimiterActive(pins[4]), .rightLimiterActive(pins[5]),
		.leftClip(pins[6]), .rightClip(pins[7]), .leftBatteryAboveThreshold(pins[8]),
		.rightBatteryAboveThreshold(pins[9]), .tempCode(tempCode), .tempValid(tempValid),
		.batCode(batCode), .batValid(batValid), .tempAdcEn(tempAdcEn),
		.leftThermalGainCut(leftCut), .rightThermalGainCut(rightCut),
		.faultReactionCfg(faultCfg), .ampShutdown(ampShutdown)
	);
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask : wt
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checksDone++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, rd);
		check(rd, e);
	endtask : rdChk
	task automatic feed(input logic isTemp, input logic [7:0] c);
		tempCode = c;
		batCode = c;
		tempValid = isTemp;
		batValid = !isTemp;
		wt(1);
		tempValid = 1'b0;
		batValid = 1'b0;
		wt(3);
	endtask : feed
	task automatic recover(input logic [7:0] m);
		u_host.wr(8'h17, 8'h80 | m);
		wt(5);
		check(ampShutdown, 1'b0);
	endtask : recover
	task automatic final_report();
		$display("checks %0d mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	initial begin
		#400000;
		miscompares++;
		final_report();
	end
	initial begin
		wt(16);
		sys_rst = 1'b0;
		wt(4);
		check(tempAdcEn, 1'b0);
		check(sdaOut, 1'b0);
		rdChk(8'h04, 8'h01);
		foreach (rstAdr[i]) rdChk(rstAdr[i], 8'h00);
		v = 8'($random(seed));
		u_host.wr(8'h0b, v);
		check(u_host.ackSeen, 1'b0);
		check(faultCfg, v);
		rdChk(8'h0b, v);
		repeat (6) begin
			pins = 10'($random(seed));
			wt(10);
			rdChk(8'h18, {pins[0], pins[1], 6'h00});
			rdChk(8'h19, {pins[5], pins[7], pins[3], pins[9],
				pins[4], pins[6], pins[2], pins[8]});
		end
		pins = '0;
		repeat (3) begin
			v = 8'($random(seed));
			feed(1'b0, v);
			rdChk(8'h1a, v);
		end
		feed(1'b1, 8'hff);
		rdChk(8'h1b, 8'h00);
		rdChk(8'h18, 8'h00);
		u_host.wr(8'h04, 8'h00);
		check(tempAdcEn, 1'b1);
		g = 8'($random(seed)) & 8'h33;
		u_host.wr(8'h16, g);
		foreach (codes[i]) begin
			t = int'(codes[i]) - 60;
			feed(1'b1, codes[i]);
			rdChk(8'h1b, codes[i]);
			rdChk(8'h18, {6'h00, t > 145, t > 117});
			check(leftCut, t > 117 ? g[1:0] : 2'b00);
			check(rightCut, t > 117 ? g[5:4] : 2'b00);
		end
		recover(8'h00);
		rdChk(8'h17, 8'h00);
		pins[2] = 1'b1;
		wt(300);
		pins[2] = 1'b0;
		wt(300);
		check(ampShutdown, 1'b1);
		foreach (pinIx[i]) begin
			lim = $random(seed) & 3;
			recover(8'(lim << 4) | modeBit[i]);
			pins[pinIx[i]] = 1'b1;
			rel = 0;
			wt(10);
			repeat (1200) begin
				wt(1);
				rel += int'(!ampShutdown);
			end
			v = pinIx[i] < 2 ? 8'h04 : 8'h01;
			check(8'(rel), (modeBit[i] & v) != 0 ? 8'(lim + 1) : 8'h00);
			check(ampShutdown, 1'b1);
			pins = '0;
		end
		// host ends with the power stage released; no bit clock is stopped here
		recover(8'h00);
		final_report();
	end
endmodule : testbench
